// *** bdi_pkg.sv ***
// Boot DMA descriptor initialisation: shared constants and types.
// Assumes a 40 MHz core clock and a 32-bit classic Wishbone register bus.
package bdi_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK   = 8'h08;
    localparam logic [7:0] OFS_DMAREG = 8'h0c;
    localparam logic [7:0] OFS_PROG   = 8'h10;
    localparam logic [7:0] OFS_TCB    = 8'h20;
    localparam logic [7:0] OFS_OTHER  = 8'h40;

    // ------------------------------------------------------------
    // Transfer control word field positions
    // ------------------------------------------------------------
    localparam int CP_LSB  = 0;
    localparam int CT_LSB  = 19;
    localparam int CE_BIT  = 23;
    localparam int RQ_BIT  = 24;
    localparam int IR_BIT  = 25;
    localparam int WS_LSB  = 26;
    localparam int TA_BIT  = 28;
    localparam int UR_BIT  = 29;
    localparam int SK_LSB  = 30;

    localparam logic [1:0] SK_NONE   = 2'h0;
    localparam logic [1:0] SK_INTMEM = 2'h1;
    localparam logic [1:0] SK_BOOTMM = 2'h2;
    localparam logic [1:0] WS_WORD   = 2'h1;
    localparam logic [1:0] WS_QUAD   = 2'h3;

    localparam logic [15:0] WORD_COUNT = 16'h0100;
    localparam logic [15:0] STEP_FOUR  = 16'h0004;
    localparam logic [15:0] STEP_ONE   = 16'h0001;
    localparam logic [31:0] ZERO_WORD  = 32'h00000000;
    localparam logic [31:0] JUMP_ADDR  = 32'h00000000;
    localparam logic [3:0]  CHAIN_TGT  = 4'h0;
    localparam logic [18:0] CHAIN_PTR  = 19'h00000;

    // Number of channel blocks that are not used for booting
    localparam int N_OTHER = 4;

    // Status bits
    localparam int ST_DONE = 0;
    localparam int ST_DREG = 1;

    typedef enum logic [1:0] {BOOT_MEMORY, BOOT_LINK, BOOT_DMAREG} bdi_mode_t;
    typedef enum {S_IDLE, S_REQ, S_WAIT, S_WRITE, S_DONE} bdi_state_t;
endpackage

// *** bdi_boot.sv ***
// Boot DMA engine: sets boot descriptors at reset, moves 256 words inward.
// Assumes external byte memory, link receiver and host share the core clock
// domain except the select strap and link valid, which are synchronised.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Memory boot loads source and destination blocks
// - Fetch 8-bit bytes into internal memory
// - Source kind: boot memory; destination: internal
// - Request external data; queue writes inward
// - Start index zero, count 256, y zero
// - Step four for listed blocks
// - Memory destination step one; word size
// - Urgency, irq set; chaining fields zero
// - Done: interrupt core, jump to zero
// - Link boot: quad destination, gating set
// - Register boot: quad destination, gating set
// - Register boot waits for first write
// - Register boot destination starts at zero
// - Select low means memory boot; high waits
// - Unused channels get source kind cleared
module bdi_boot (
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        BOOT_MEM_SEL_B,
    output logic             BOOT_MEM_CS_B,
    output logic [31:0]      BOOT_MEM_ADDR,
    output logic             BOOT_MEM_RD,
    input  wire logic [7:0]  BOOT_MEM_DATA,
    input  wire logic        BOOT_MEM_VALID,
    input  wire logic        LINK_VALID,
    input  wire logic [31:0] LINK_DATA,
    output logic             IMEM_WE,
    output logic [31:0]      IMEM_ADDR,
    output logic [31:0]      IMEM_WDATA,
    output logic             CORE_IRQ,
    output logic             CORE_JUMP,
    output logic [31:0]      CORE_JUMP_ADDR,
    output logic             IRQ,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O
);
    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [1:0] sel_sync_r;
    logic [1:0] link_sync_r;
    logic       strap_taken_r;
    logic       mem_boot_r;
    logic [1:0] settle_r;

    // Two flops per pin; only the second stage is read
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sel_sync_r  <= 2'h3;
            link_sync_r <= 2'h0;
        end else begin
            sel_sync_r  <= {sel_sync_r[0], BOOT_MEM_SEL_B};
            link_sync_r <= {link_sync_r[0], LINK_VALID};
        end
    end

    // Strap is caught once, after the reset value has left both sync stages
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_taken_r <= 1'b0;
            mem_boot_r    <= 1'b0;
            settle_r      <= 2'h0;
        end else begin
            if (settle_r != 2'h3) settle_r <= settle_r + 2'h1;
            if (!strap_taken_r && settle_r == 2'h2) begin
                strap_taken_r <= 1'b1;
                mem_boot_r    <= ~sel_sync_r[1];
            end
        end
    end

    // ------------------------------------------------------------
    // Descriptor state
    // ------------------------------------------------------------
    bdi_pkg::bdi_state_t state_r;
    bdi_pkg::bdi_mode_t  mode_r;
    logic [31:0] src_idx_r;
    logic [15:0] dst_cnt_r;
    logic [31:0] dst_idx_r;
    logic [1:0]  byte_r;
    logic [31:0] asm_r;
    logic [31:0] ctrl_r;
    logic [1:0]  status_r;
    logic [1:0]  mask_r;
    logic        jump_r;
    logic [31:0] dreg_r;

    wire [15:0] dst_step = (mode_r == bdi_pkg::BOOT_MEMORY) ? bdi_pkg::STEP_ONE
                                                            : bdi_pkg::STEP_FOUR;
    wire [1:0]  dst_ws   = (mode_r == bdi_pkg::BOOT_MEMORY) ? bdi_pkg::WS_WORD
                                                            : bdi_pkg::WS_QUAD;
    wire        dst_rq   = (mode_r != bdi_pkg::BOOT_MEMORY);

    // Control word assembly shared by both blocks
    function automatic logic [31:0] mk_ctrl(input logic [1:0] sk, input logic [1:0] ws,
                                            input logic rq);
        logic [31:0] w;
        w = bdi_pkg::ZERO_WORD;
        w[bdi_pkg::SK_LSB +: 2] = sk;
        w[bdi_pkg::UR_BIT]      = 1'b1;
        w[bdi_pkg::TA_BIT]      = 1'b0;
        w[bdi_pkg::WS_LSB +: 2] = ws;
        w[bdi_pkg::IR_BIT]      = 1'b1;
        w[bdi_pkg::RQ_BIT]      = rq;
        w[bdi_pkg::CE_BIT]      = 1'b0;
        w[bdi_pkg::CT_LSB +: 4] = bdi_pkg::CHAIN_TGT;
        w[bdi_pkg::CP_LSB +: 19] = bdi_pkg::CHAIN_PTR;
        return w;
    endfunction

    wire [31:0] src_word = mk_ctrl(mem_boot_r ? bdi_pkg::SK_BOOTMM : bdi_pkg::SK_NONE,
                                   bdi_pkg::WS_WORD, 1'b0);
    wire [31:0] dst_word = mk_ctrl(bdi_pkg::SK_INTMEM, dst_ws, dst_rq);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        bus_req  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire        wr_ctrl  = bus_req && WB_WE_I && WB_ADR_I == bdi_pkg::OFS_CTRL;
    wire        wr_mask  = bus_req && WB_WE_I && WB_ADR_I == bdi_pkg::OFS_MASK;
    wire        wr_dreg  = bus_req && WB_WE_I && WB_ADR_I == bdi_pkg::OFS_DMAREG
                           && WB_SEL_I == 4'hf;
    wire        rd_stat  = bus_req && !WB_WE_I && WB_ADR_I == bdi_pkg::OFS_STATUS;
    wire [4:0]  tcb_sel  = WB_ADR_I[6:2];
    logic [31:0] rd_mux;

    // Descriptor table readback; source block words 0..3, destination 4..7
    always_comb begin
        rd_mux = bdi_pkg::ZERO_WORD;
        if (WB_ADR_I == bdi_pkg::OFS_CTRL) rd_mux = ctrl_r;
        else if (WB_ADR_I == bdi_pkg::OFS_STATUS) rd_mux = {30'h0, status_r};
        else if (WB_ADR_I == bdi_pkg::OFS_MASK) rd_mux = {30'h0, mask_r};
        else if (WB_ADR_I == bdi_pkg::OFS_DMAREG) rd_mux = dreg_r;
        else if (WB_ADR_I == bdi_pkg::OFS_PROG) rd_mux = {16'h0, dst_cnt_r};
        else if (WB_ADR_I == bdi_pkg::OFS_TCB) rd_mux = bdi_pkg::ZERO_WORD;
        else if (WB_ADR_I == bdi_pkg::OFS_TCB + 8'h04)
            rd_mux = {bdi_pkg::WORD_COUNT, bdi_pkg::STEP_FOUR};
        else if (WB_ADR_I == bdi_pkg::OFS_TCB + 8'h08) rd_mux = bdi_pkg::ZERO_WORD;
        else if (WB_ADR_I == bdi_pkg::OFS_TCB + 8'h0c) rd_mux = src_word;
        else if (WB_ADR_I == bdi_pkg::OFS_TCB + 8'h10) rd_mux = dst_idx_r;
        // Loaded count is shown; live progress stands at the progress word
        else if (WB_ADR_I == bdi_pkg::OFS_TCB + 8'h14)
            rd_mux = {bdi_pkg::WORD_COUNT, dst_step};
        else if (WB_ADR_I == bdi_pkg::OFS_TCB + 8'h18) rd_mux = bdi_pkg::ZERO_WORD;
        else if (WB_ADR_I == bdi_pkg::OFS_TCB + 8'h1c) rd_mux = dst_word;
        else if (WB_ADR_I >= bdi_pkg::OFS_OTHER && tcb_sel < 5'h14)
            rd_mux = bdi_pkg::ZERO_WORD;
    end

    // One-wait-state slave; unmapped reads return zero, writes ignored
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
        end else begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------
    wire link_take = link_sync_r[1] && state_r == bdi_pkg::S_WAIT
                     && mode_r == bdi_pkg::BOOT_LINK;
    wire dreg_take = wr_dreg && state_r == bdi_pkg::S_WAIT
                     && mode_r == bdi_pkg::BOOT_DMAREG;
    wire mem_take  = BOOT_MEM_VALID && state_r == bdi_pkg::S_WAIT
                     && mode_r == bdi_pkg::BOOT_MEMORY;
    wire last_byte = byte_r == 2'h3;
    wire done_evt  = state_r == bdi_pkg::S_WRITE && dst_cnt_r == 16'h0001;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r   <= bdi_pkg::S_IDLE;
            mode_r    <= bdi_pkg::BOOT_DMAREG;
            src_idx_r <= 32'h0;
            dst_idx_r <= 32'h0;
            dst_cnt_r <= 16'h0100;
            byte_r    <= 2'h0;
            asm_r     <= 32'h0;
            jump_r    <= 1'b0;
            dreg_r    <= 32'h0;
        end else begin
            jump_r <= 1'b0;
            case (state_r)
                bdi_pkg::S_IDLE: begin
                    src_idx_r <= bdi_pkg::ZERO_WORD;
                    dst_idx_r <= bdi_pkg::ZERO_WORD;
                    dst_cnt_r <= bdi_pkg::WORD_COUNT;
                    if (strap_taken_r) begin
                        // Host boot picks link mode if link data shows up first
                        mode_r  <= mem_boot_r ? bdi_pkg::BOOT_MEMORY : bdi_pkg::BOOT_DMAREG;
                        state_r <= mem_boot_r ? bdi_pkg::S_REQ : bdi_pkg::S_WAIT;
                    end
                end
                bdi_pkg::S_REQ: begin
                    state_r <= bdi_pkg::S_WAIT;
                end
                bdi_pkg::S_WAIT: begin
                    if (mode_r == bdi_pkg::BOOT_DMAREG && link_sync_r[1]
                        && dst_cnt_r == bdi_pkg::WORD_COUNT)
                        mode_r <= bdi_pkg::BOOT_LINK;
                    if (mem_take) begin
                        // Least significant byte arrives first
                        asm_r     <= {BOOT_MEM_DATA, asm_r[31:8]};
                        byte_r    <= byte_r + 2'h1;
                        src_idx_r <= src_idx_r + 32'h1;
                        state_r   <= last_byte ? bdi_pkg::S_WRITE : bdi_pkg::S_REQ;
                    end else if (link_take) begin
                        asm_r   <= LINK_DATA;
                        state_r <= bdi_pkg::S_WRITE;
                    end else if (dreg_take) begin
                        asm_r   <= WB_DAT_I;
                        dreg_r  <= WB_DAT_I;
                        state_r <= bdi_pkg::S_WRITE;
                    end
                end
                bdi_pkg::S_WRITE: begin
                    dst_idx_r <= dst_idx_r + {16'h0, dst_step};
                    dst_cnt_r <= dst_cnt_r - 16'h1;
                    if (done_evt) begin
                        jump_r  <= 1'b1;
                        state_r <= bdi_pkg::S_DONE;
                    end else begin
                        state_r <= mode_r == bdi_pkg::BOOT_MEMORY ? bdi_pkg::S_REQ
                                                                   : bdi_pkg::S_WAIT;
                    end
                end
                default: state_r <= bdi_pkg::S_DONE;
            endcase
        end
    end

    // Inbound queue write: address from destination block
    assign IMEM_WE    = state_r == bdi_pkg::S_WRITE;
    assign IMEM_ADDR  = dst_idx_r;
    assign IMEM_WDATA = asm_r;
    assign BOOT_MEM_RD   = state_r == bdi_pkg::S_REQ;
    assign BOOT_MEM_CS_B = !(mode_r == bdi_pkg::BOOT_MEMORY &&
                             (state_r == bdi_pkg::S_REQ || state_r == bdi_pkg::S_WAIT));
    assign BOOT_MEM_ADDR = src_idx_r;
    assign CORE_JUMP      = jump_r;
    assign CORE_JUMP_ADDR = bdi_pkg::JUMP_ADDR;
    assign CORE_IRQ       = state_r == bdi_pkg::S_DONE;

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            status_r <= 2'h0;
            mask_r   <= 2'h0;
            ctrl_r   <= 32'h0;
        end else begin
            // Set wins over the clearing read
            status_r <= (rd_stat ? 2'h0 : status_r) | {dreg_take, jump_r};
            if (wr_mask) mask_r <= WB_DAT_I[1:0];
            if (wr_ctrl) ctrl_r <= WB_DAT_I;
        end
    end

    assign IRQ = |(status_r & mask_r);
endmodule
`default_nettype wire

// *** bdi_boot_asserts.sv ***
// Port assertions for the boot engine: bus answer, fetch, completion.
// Assumes binding onto bdi_boot; one clock, asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module bdi_boot_asserts (
    input wire logic        CLK,
    input wire logic        RST_B,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_ACK_O,
    input wire logic        BOOT_MEM_RD,
    input wire logic        BOOT_MEM_CS_B,
    input wire logic        IMEM_WE,
    input wire logic [31:0] IMEM_ADDR,
    input wire logic        CORE_IRQ,
    input wire logic        CORE_JUMP,
    input wire logic [31:0] CORE_JUMP_ADDR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // ----------------------------------------------------------
    // Output timing tied to its cause
    // ----------------------------------------------------------
    ack_after_take_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not answered next cycle");
    ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus answer longer than one cycle");
    rd_needs_cs_a: assert property (BOOT_MEM_RD |-> !BOOT_MEM_CS_B)
        else $error("byte request without chip select");
    rd_single_a: assert property (BOOT_MEM_RD |=> !BOOT_MEM_RD)
        else $error("byte request longer than one cycle");
    write_range_a: assert property (IMEM_WE |-> IMEM_ADDR < 32'h00000400)
        else $error("inward write beyond boot block");
    write_pulse_a: assert property (IMEM_WE |=> !IMEM_WE)
        else $error("inward write longer than one cycle");
    jump_zero_a: assert property (CORE_JUMP |-> CORE_JUMP_ADDR == 32'h00000000)
        else $error("jump target not zero");
    jump_irq_a: assert property (CORE_JUMP |-> ##[0:1] CORE_IRQ)
        else $error("no core interrupt with jump");
    jump_once_a: assert property (CORE_JUMP |=> !CORE_JUMP [*8])
        else $error("jump repeated");
    irq_holds_a: assert property (CORE_IRQ |=> CORE_IRQ)
        else $error("core interrupt dropped");
endmodule
bind bdi_boot bdi_boot_asserts u_chk (.CLK, .RST_B, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
    .BOOT_MEM_RD, .BOOT_MEM_CS_B, .IMEM_WE, .IMEM_ADDR, .CORE_IRQ, .CORE_JUMP,
    .CORE_JUMP_ADDR);
`default_nettype wire

// *** bdi_bootmem_model.sv ***
// Byte-wide boot memory answering the engine's byte requests.
// Assumes requests are one-cycle pulses qualified by chip select.
`timescale 1ns/10ps
`default_nettype none
module bdi_bootmem_model (
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        BOOT_MEM_CS_B,
    input  wire logic [31:0] BOOT_MEM_ADDR,
    input  wire logic        BOOT_MEM_RD,
    output logic [7:0]       BOOT_MEM_DATA,
    output logic             BOOT_MEM_VALID
);
    logic       busy_r;
    logic       slow_r;
    logic [1:0] wait_r;
    logic [7:0] byte_r;
    // ----------------------------------------------------------
    // Answer: alternately prompt and two cycles late
    // ----------------------------------------------------------
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            busy_r <= 1'b0;
            slow_r <= 1'b0;
            wait_r <= 2'h0;
            byte_r <= 8'h00;
            BOOT_MEM_VALID <= 1'b0;
            BOOT_MEM_DATA <= 8'h00;
        end else begin
            BOOT_MEM_VALID <= 1'b0;
            BOOT_MEM_DATA <= ~BOOT_MEM_DATA; // Released data wanders, never holds
            if (BOOT_MEM_RD && !BOOT_MEM_CS_B) begin
                busy_r <= 1'b1;
                wait_r <= slow_r ? 2'h2 : 2'h0;
                slow_r <= ~slow_r;
                // Image stored least significant byte first
                byte_r <= BOOT_MEM_ADDR[7:0] ^ {BOOT_MEM_ADDR[9:8], 6'h15};
            end else if (busy_r && wait_r == 2'h0) begin
                busy_r <= 1'b0;
                BOOT_MEM_VALID <= 1'b1;
                BOOT_MEM_DATA <= byte_r;
            end else if (busy_r) begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Bench for the boot engine: memory boot, then register boot.
// Assumes bdi_boot, the boot memory model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        CLK = 1'b0;
    logic        RST_B = 1'b0;
    logic        BOOT_MEM_SEL_B = 1'b0;
    logic        WB_CYC_I = 1'b0;
    logic        WB_STB_I = 1'b0;
    logic        WB_WE_I = 1'b0;
    logic [7:0]  WB_ADR_I = 8'h00;
    logic [3:0]  WB_SEL_I = 4'hf;
    logic [31:0] WB_DAT_I = 32'h0;
    logic        BOOT_MEM_CS_B, BOOT_MEM_RD, BOOT_MEM_VALID, IMEM_WE;
    logic        CORE_IRQ, CORE_JUMP, IRQ, WB_ACK_O, regmode;
    logic [7:0]  BOOT_MEM_DATA;
    logic [31:0] BOOT_MEM_ADDR, IMEM_ADDR, IMEM_WDATA, CORE_JUMP_ADDR, WB_DAT_O, q;
    logic [31:0] rdat [256];
    int          error_cnt = 0;
    int          checks_done = 0;
    int          wcnt = 0;
    int          jumps = 0;
    always #12.5 CLK = ~CLK;
    bdi_boot uut (.CLK, .RST_B, .BOOT_MEM_SEL_B, .BOOT_MEM_CS_B, .BOOT_MEM_ADDR,
        .BOOT_MEM_RD, .BOOT_MEM_DATA, .BOOT_MEM_VALID, .LINK_VALID(1'b0),
        .LINK_DATA(32'h0), .IMEM_WE, .IMEM_ADDR, .IMEM_WDATA, .CORE_IRQ, .CORE_JUMP,
        .CORE_JUMP_ADDR, .IRQ, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
        .WB_DAT_I, .WB_DAT_O, .WB_ACK_O);
    bdi_bootmem_model u_mem (.CLK, .RST_B, .BOOT_MEM_CS_B, .BOOT_MEM_ADDR, .BOOT_MEM_RD,
        .BOOT_MEM_DATA, .BOOT_MEM_VALID);
    // ----------------------------------------------------------
    // Checking and bus helpers
    // ----------------------------------------------------------
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic timed_out(input string n);
        error_cnt++;
        $display("ERROR %s expected answer seen timeout", n);
        summarize();
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] sk, input logic [1:0] ws,
                                        input logic rq);
        return {sk, 1'b1, 1'b0, ws, 1'b1, rq, 1'b0, 4'h0, 19'h00000};
    endfunction
    // Word n of the boot image, assembled least significant byte first
    function automatic logic [31:0] memword(input int n);
        logic [31:0] a;
        logic [31:0] w;
        for (int k = 0; k < 4; k++) begin
            a = 32'(4 * n + k);
            w[8*k +: 8] = a[7:0] ^ {a[9:8], 6'h15};
        end
        return w;
    endfunction
    // Single classic cycle; held until acknowledge is sampled high
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        WB_SEL_I <= s;
        do begin
            @(posedge CLK);
            n++;
            if (n > 50) timed_out("wb_ack");
        end while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        wb(1'b0, a, 32'h0, 4'hf);
        chk(n, e, q);
    endtask
    task automatic boot_reset(input logic sel);
        @(posedge CLK);
        RST_B <= 1'b0;
        BOOT_MEM_SEL_B <= sel;
        regmode = sel;
        repeat (3) @(posedge CLK);
        wcnt = 0;
        jumps = 0;
        RST_B <= 1'b1;
        repeat (4) @(posedge CLK); // Strap passes its two sync stages first
    endtask
    task automatic wait_jump;
        int n;
        n = 0;
        while (jumps == 0) begin
            @(posedge CLK);
            n++;
            if (n > 20000) timed_out("core_jump");
        end
    endtask
    // Inward writes: address step and data per boot mode
    always @(posedge CLK) begin
        if (RST_B === 1'b1 && IMEM_WE === 1'b1) begin
            chk("imem_addr", regmode ? 32'(wcnt * 4) : 32'(wcnt), IMEM_ADDR);
            chk("imem_data", regmode ? rdat[wcnt % 256] : memword(wcnt), IMEM_WDATA);
            wcnt = wcnt + 1;
        end
        if (CORE_JUMP === 1'b1) jumps = jumps + 1;
    end
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_memboot;
        boot_reset(1'b0);
        rd(8'h20, 32'h0, "src_index");
        rd(8'h24, 32'h01000004, "src_countstep");
        rd(8'h28, 32'h0, "src_y");
        rd(8'h2c, ctl(2'h2, 2'h1, 1'b0), "src_ctrl");
        rd(8'h34, 32'h01000001, "dst_countstep");
        rd(8'h38, 32'h0, "dst_y");
        rd(8'h3c, ctl(2'h1, 2'h1, 1'b0), "dst_ctrl");
        rd(8'h4c, 32'h0, "other_ctrl");
        wait_jump();
        chk("mem_words", 32'd256, 32'(wcnt));
        chk("core_irq", 32'h1, {31'h0, CORE_IRQ});
        chk("fetch_cs", 32'h1, {31'h0, BOOT_MEM_CS_B});
        chk("irq_masked", 32'h0, {31'h0, IRQ});
        wb(1'b1, 8'h08, 32'h1, 4'hf);
        @(posedge CLK);
        chk("irq_unmasked", 32'h1, {31'h0, IRQ});
        rd(8'h04, 32'h1, "status");
        @(posedge CLK);
        chk("irq_cleared", 32'h0, {31'h0, IRQ});
    endtask
    task automatic t_regboot;
        boot_reset(1'b1);
        rd(8'h30, 32'h0, "reg_dst_index");
        rd(8'h34, 32'h01000004, "reg_dst_countstep");
        rd(8'h3c, ctl(2'h1, 2'h3, 1'b1), "reg_dst_ctrl");
        rd(8'h10, 32'h100, "words_left");
        chk("fetch_idle", 32'h1, {31'h0, BOOT_MEM_CS_B});
        wb(1'b1, 8'h0c, 32'hdeadbeef, 4'h3); // Partial write must be ignored
        chk("no_start", 32'h0, 32'(wcnt));
        for (int i = 0; i < 256; i++) begin
            rdat[i] = 32'ha5000000 ^ (32'(i) * 32'h00010203);
            wb(1'b1, 8'h0c, rdat[i], 4'hf);
        end
        wait_jump();
        chk("reg_words", 32'd256, 32'(wcnt));
        rd(8'h04, 32'h3, "reg_status");
        rd(8'h7c, 32'h0, "unmapped");
    endtask
    initial begin
        t_memboot();
        t_regboot();
        summarize();
    end
endmodule
`default_nettype wire
